// ==== hdl/pdiu_params.svh ====
// Offsets, field positions, reset values and sizes of the interrupt unit
`ifndef PDIU_PARAMS_SVH
`define PDIU_PARAMS_SVH

`define PDIU_OFS_CTRL     8'h00
`define PDIU_OFS_TRIG     8'h04
`define PDIU_OFS_EDGE     8'h08
`define PDIU_OFS_BASE     8'h0C
`define PDIU_OFS_PWORD    8'h10
`define PDIU_OFS_DWORD    8'h14
`define PDIU_OFS_STAT     8'h18
`define PDIU_OFS_ACK      8'h1C

`define PDIU_CTRL_MODE_LO 0
`define PDIU_CTRL_SEL_DP  2
`define PDIU_CTRL_DIAG_EN 3
`define PDIU_CTRL_SWGATE  4

`define PDIU_TRIG_OVF_LO  0
`define PDIU_TRIG_CMP_LO  4
`define PDIU_TRIG_GOPEN   8
`define PDIU_TRIG_GCLOSE  9
`define PDIU_TRIG_LATCH   10
`define PDIU_TRIG_FEND_LO 11

`define PDIU_ACK_PROC     0
`define PDIU_ACK_DIAG     1

`define PDIU_RST_CTRL     8'h00
`define PDIU_RST_TRIG     16'h0000
`define PDIU_RST_EDGE     16'h0000
`define PDIU_RST_BASE     16'h0000

`define PDIU_SRC_NUM      7
`define PDIU_SRC_OUT_SUP  4
`define PDIU_SRC_IN_SUP   5
`define PDIU_SRC_DO_SHORT 6
`define PDIU_QDEPTH       8
`define PDIU_QAW          3

`endif

// ==== hdl/pdiu_pkg.sv ====
// Types shared by the interrupt unit
package pdiu_pkg;
	typedef enum logic [1:0] {
		PDIU_ST_IDLE = 2'b00,
		PDIU_ST_PROC = 2'b01,
		PDIU_ST_DIAG = 2'b10,
		PDIU_ST_NEST = 2'b11
	} pdiu_state_t;

	typedef enum logic [1:0] {
		PDIU_MODE_ALARM = 2'b00,
		PDIU_MODE_COUNT = 2'b01,
		PDIU_MODE_FREQ  = 2'b10,
		PDIU_MODE_OFF   = 2'b11
	} pdiu_mode_t;

	typedef struct packed {
		logic [3:0] src;
		logic       outgoing;
	} pdiu_qent_t;
endpackage

// ==== hdl/pdiu_diag_queue.sv ====
// Ordered queue of pending diagnostic handler calls
`timescale 1ns/1ps
`include "pdiu_params.svh"
module pdiu_diag_queue
	import pdiu_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_rstn,
	input  wire logic       i_push,
	input  wire pdiu_qent_t i_data,
	input  wire logic       i_pop,
	output pdiu_qent_t      o_data,
	output logic            o_empty,
	output logic            o_full
);
	typedef struct packed {
		pdiu_qent_t [`PDIU_QDEPTH-1:0] mem;
		logic [`PDIU_QAW-1:0]          wp;
		logic [`PDIU_QAW-1:0]          rp;
		logic [`PDIU_QAW:0]            cnt;
	} pdiu_q_t;

	pdiu_q_t q_ff;
	pdiu_q_t nxt_q;
	logic    do_push;
	logic    do_pop;

	assign o_empty = (q_ff.cnt == '0);
	assign o_full  = (q_ff.cnt == (`PDIU_QAW+1)'(`PDIU_QDEPTH));
	assign o_data  = q_ff.mem[q_ff.rp];
	assign do_push = i_push && !o_full;
	assign do_pop  = i_pop && !o_empty;

	always_comb begin
		nxt_q = q_ff;
		if (do_push) begin
			nxt_q.mem[q_ff.wp] = i_data;
			nxt_q.wp = q_ff.wp + 1'b1;
		end
		if (do_pop) begin
			nxt_q.rp = q_ff.rp + 1'b1;
		end
		if (do_push && !do_pop) begin
			nxt_q.cnt = q_ff.cnt + 1'b1;
		end else if (do_pop && !do_push) begin
			nxt_q.cnt = q_ff.cnt - 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end
endmodule

// ==== hdl/pdiu_top.sv ====
// Process and diagnostic interrupt unit of the on-board I/O periphery
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
`include "pdiu_params.svh"
module pdiu_top
	import pdiu_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [15:0] i_di_pin,
	input  wire logic        i_out_sup_fail,
	input  wire logic        i_in_sup_fail,
	input  wire logic        i_elec_sup_fail,
	input  wire logic        i_do_short,
	input  wire logic [3:0]  i_cnt_ovf,
	input  wire logic [3:0]  i_cnt_cmp,
	input  wire logic        i_cnt3_gate_open,
	input  wire logic        i_cnt3_gate_close,
	input  wire logic        i_cnt3_latch,
	input  wire logic [3:0]  i_freq_end,
	input  wire logic [1:0]  i_pulse_out,
	output logic [31:0]      o_rdata,
	output logic             o_proc_irq,
	output logic             o_diag_irq,
	output logic             o_diag_buf_we,
	output logic [3:0]       o_diag_buf_src,
	output logic             o_diag_buf_out,
	output logic             o_sys_fault_led,
	output logic [1:0]       o_pulse_led,
	output logic             o_out_gnd_fault_led,
	output logic             o_elec_sup_led,
	output logic             o_in_sup_led,
	output logic             o_out_sup_led
);
	typedef struct packed {
		logic [15:0]               di_s1;
		logic [15:0]               di_s2;
		logic [15:0]               di_prev;
		logic [3:0]                flt_s1;
		logic [3:0]                flt_s2;
		logic [3:0]                flt_prev;
		logic [7:0]                ctrl;
		logic [15:0]               trig;
		logic [15:0]               edge_en;
		logic [15:0]               base;
		logic [31:0]               pend;
		logic [31:0]               pword;
		logic [15:0]               pbase;
		logic [3:0]                pset;
		pdiu_qent_t                dword;
		pdiu_state_t               st;
		logic [`PDIU_SRC_NUM-1:0]  win;
		logic [`PDIU_SRC_NUM-1:0]  req_in;
		logic [`PDIU_SRC_NUM-1:0]  req_out;
		logic [31:0]               rdata;
		logic                      proc_irq;
		logic                      diag_irq;
		logic                      buf_we;
		logic [3:0]                buf_src;
		logic                      buf_out;
		logic                      system_fault_indicator;
		logic [1:0]                pulse_led;
		logic                      gnd_led;
		logic [2:0]                sup_led;
	} pdiu_st_t;

	pdiu_st_t   s_ff;
	pdiu_st_t   nxt_s;
	logic       q_push;
	pdiu_qent_t q_wdata;
	logic       q_pop;
	pdiu_qent_t q_rdata;
	logic       q_empty;
	logic       q_full;

	// Event byte of one channel for the configured mode
	function automatic logic [7:0] chan_events(input pdiu_mode_t mode, input int unsigned c,
		input logic [15:0] edges, input logic [15:0] trig, input logic swgate);
		logic [7:0] ev;
		ev = 8'h00;
		case (mode)
			PDIU_MODE_ALARM: begin
				if (c == 0) begin
					ev = edges[7:0];
				end else if (c == 1) begin
					ev = edges[15:8];
				end
			end
			PDIU_MODE_COUNT: begin
				ev[2] = i_cnt_ovf[c] && trig[`PDIU_TRIG_OVF_LO+c];
				ev[3] = i_cnt_cmp[c] && trig[`PDIU_TRIG_CMP_LO+c];
				if (c == 3) begin
					ev[0] = i_cnt3_gate_open && swgate && trig[`PDIU_TRIG_GOPEN];
					ev[1] = i_cnt3_gate_close && swgate && trig[`PDIU_TRIG_GCLOSE];
					ev[4] = i_cnt3_latch && trig[`PDIU_TRIG_LATCH];
				end
			end
			PDIU_MODE_FREQ: begin
				ev[0] = i_freq_end[c] && trig[`PDIU_TRIG_FEND_LO+c];
			end
			default: begin
				ev = 8'h00;
			end
		endcase
		return ev;
	endfunction

	pdiu_diag_queue u_queue (
		.i_mclk  (i_mclk),
		.i_rstn  (i_rstn),
		.i_push  (q_push),
		.i_data  (q_wdata),
		.i_pop   (q_pop),
		.o_data  (q_rdata),
		.o_empty (q_empty),
		.o_full  (q_full)
	);

	always_comb begin
		logic [15:0] edges;
		logic [3:0]  flt_rise;
		logic [3:0]  flt_fall;
		logic [7:0]  ev;
		logic        diag_en;
		logic        sel_dp;
		logic        picked;
		logic        ack_proc;
		logic        ack_diag;
		logic        diag_pend;
		pdiu_mode_t  mode;
		edges    = '0;
		flt_rise = '0;
		flt_fall = '0;
		ev       = '0;
		picked   = 1'b0;
		diag_pend = 1'b0;
		nxt_s    = s_ff;
		q_push   = 1'b0;
		q_wdata  = '0;
		q_pop    = 1'b0;
		mode     = pdiu_mode_t'(s_ff.ctrl[`PDIU_CTRL_MODE_LO +: 2]);
		diag_en  = s_ff.ctrl[`PDIU_CTRL_DIAG_EN];
		sel_dp   = s_ff.ctrl[`PDIU_CTRL_SEL_DP];
		ack_proc = i_wr && (i_addr == `PDIU_OFS_ACK) && i_wdata[`PDIU_ACK_PROC];
		ack_diag = i_wr && (i_addr == `PDIU_OFS_ACK) && i_wdata[`PDIU_ACK_DIAG];

		// Pin synchronisers
		nxt_s.di_s1    = i_di_pin;
		nxt_s.di_s2    = s_ff.di_s1;
		nxt_s.di_prev  = s_ff.di_s2;
		nxt_s.flt_s1   = {i_elec_sup_fail, i_do_short, i_in_sup_fail, i_out_sup_fail};
		nxt_s.flt_s2   = s_ff.flt_s1;
		nxt_s.flt_prev = s_ff.flt_s2;
		edges    = (s_ff.di_s2 ^ s_ff.di_prev) & s_ff.edge_en;
		flt_rise = s_ff.flt_s2 & ~s_ff.flt_prev;
		flt_fall = ~s_ff.flt_s2 & s_ff.flt_prev;

		// Register writes
		if (i_wr) begin
			if (i_addr == `PDIU_OFS_CTRL) begin
				nxt_s.ctrl = i_wdata[7:0];
			end else if (i_addr == `PDIU_OFS_TRIG) begin
				nxt_s.trig = i_wdata[15:0];
			end else if (i_addr == `PDIU_OFS_EDGE) begin
				nxt_s.edge_en = i_wdata[15:0];
			end else if (i_addr == `PDIU_OFS_BASE) begin
				nxt_s.base = i_wdata[15:0];
			end
		end

		// Register reads, data one cycle later
		nxt_s.rdata = 32'h0000_0000;
		if (i_rd) begin
			if (i_addr == `PDIU_OFS_CTRL) begin
				nxt_s.rdata = {24'h00_0000, s_ff.ctrl};
			end else if (i_addr == `PDIU_OFS_TRIG) begin
				nxt_s.rdata = {16'h0000, s_ff.trig};
			end else if (i_addr == `PDIU_OFS_EDGE) begin
				nxt_s.rdata = {16'h0000, s_ff.edge_en};
			end else if (i_addr == `PDIU_OFS_BASE) begin
				nxt_s.rdata = {16'h0000, s_ff.base};
			end else if (i_addr == `PDIU_OFS_PWORD) begin
				nxt_s.rdata = s_ff.pword;
			end else if (i_addr == `PDIU_OFS_DWORD) begin
				nxt_s.rdata = {27'h000_0000, s_ff.dword};
			end else if (i_addr == `PDIU_OFS_STAT) begin
				nxt_s.rdata = {s_ff.pbase, 5'h00, s_ff.win, q_full, q_empty, s_ff.st};
			end
		end

		// Handler completion
		if (ack_proc && (s_ff.st == PDIU_ST_PROC)) begin
			for (int c = 0; c < 4; c++) begin
				if (s_ff.pset[c] && s_ff.win[c]) begin
					if (diag_en) begin
						nxt_s.req_out[c] = 1'b1;
					end else begin
						nxt_s.win[c] = 1'b0;
					end
				end
			end
			nxt_s.pset = 4'h0;
			nxt_s.st   = PDIU_ST_IDLE;
		end else if (ack_diag && (s_ff.st == PDIU_ST_DIAG)) begin
			nxt_s.st = PDIU_ST_IDLE;
		end else if (ack_diag && (s_ff.st == PDIU_ST_NEST)) begin
			nxt_s.st = PDIU_ST_PROC;
		end

		// Requests not yet queued hold back process calls
		diag_pend = (s_ff.req_in != '0) || (nxt_s.req_out != '0);

		// Dispatch: queued diagnostics before any process call
		if (!q_empty && ((nxt_s.st == PDIU_ST_IDLE) || (nxt_s.st == PDIU_ST_PROC))) begin
			q_pop       = 1'b1;
			nxt_s.dword = q_rdata;
			nxt_s.st    = (nxt_s.st == PDIU_ST_PROC) ? PDIU_ST_NEST : PDIU_ST_DIAG;
			nxt_s.buf_we  = 1'b1;
			nxt_s.buf_src = q_rdata.src;
			nxt_s.buf_out = q_rdata.outgoing;
			if (q_rdata.outgoing) begin
				nxt_s.win[q_rdata.src[2:0]] = 1'b0;
			end
		end else begin
			nxt_s.buf_we = 1'b0;
			if (q_empty && !diag_pend && (nxt_s.st == PDIU_ST_IDLE) && (s_ff.pend != 32'h0)) begin
				nxt_s.pword = s_ff.pend;
				nxt_s.pbase = s_ff.base;
				for (int c = 0; c < 4; c++) begin
					nxt_s.pset[c] = (s_ff.pend[8*c +: 8] != 8'h00);
				end
				nxt_s.pend = 32'h0;
				nxt_s.st   = PDIU_ST_PROC;
			end
		end

		// Channel events
		for (int unsigned c = 0; c < 4; c++) begin
			ev = sel_dp ? chan_events(mode, c, edges, s_ff.trig, s_ff.ctrl[`PDIU_CTRL_SWGATE]) : 8'h00;
			if (ev != 8'h00) begin
				if (s_ff.win[c]) begin
					ev = 8'h00;
				end else if (s_ff.pset[c] && ((ev & s_ff.pword[8*c +: 8]) != 8'h00) && diag_en) begin
					nxt_s.req_in[c] = 1'b1;
					nxt_s.win[c]    = 1'b1;
				end else begin
					nxt_s.pend[8*c +: 8] = nxt_s.pend[8*c +: 8] | ev;
				end
			end
		end

		// Supply and output faults
		for (int f = 0; f < 3; f++) begin
			if (flt_rise[f] && diag_en && !s_ff.win[4+f]) begin
				nxt_s.req_in[4+f] = 1'b1;
				nxt_s.win[4+f]    = 1'b1;
			end else if (flt_fall[f] && s_ff.win[4+f]) begin
				if (diag_en) begin
					nxt_s.req_out[4+f] = 1'b1;
				end else begin
					nxt_s.win[4+f] = 1'b0;
				end
			end
		end

		// One queue entry per cycle, lowest source first
		for (int j = 0; j < `PDIU_SRC_NUM; j++) begin
			if (!picked && !q_full && s_ff.req_in[j]) begin
				picked = 1'b1;
				q_push = 1'b1;
				q_wdata.src = 4'(j);
				q_wdata.outgoing = 1'b0;
				nxt_s.req_in[j] = 1'b0;
			end else if (!picked && !q_full && s_ff.req_out[j] && !s_ff.req_in[j]) begin
				picked = 1'b1;
				q_push = 1'b1;
				q_wdata.src = 4'(j);
				q_wdata.outgoing = 1'b1;
				nxt_s.req_out[j] = 1'b0;
			end
		end

		// Outputs and indicators
		nxt_s.proc_irq  = (nxt_s.st == PDIU_ST_PROC);
		nxt_s.diag_irq  = (nxt_s.st == PDIU_ST_DIAG) || (nxt_s.st == PDIU_ST_NEST);
		nxt_s.system_fault_indicator    = (nxt_s.win != '0);
		nxt_s.pulse_led = i_pulse_out;
		nxt_s.gnd_led   = s_ff.flt_s2[2];
		nxt_s.sup_led   = ~{s_ff.flt_s2[1], s_ff.flt_s2[0], s_ff.flt_s2[3]};
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			s_ff         <= '0;
			s_ff.ctrl    <= `PDIU_RST_CTRL;
			s_ff.trig    <= `PDIU_RST_TRIG;
			s_ff.edge_en <= `PDIU_RST_EDGE;
			s_ff.base    <= `PDIU_RST_BASE;
			s_ff.st      <= PDIU_ST_IDLE;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign o_rdata             = s_ff.rdata;
	assign o_proc_irq          = s_ff.proc_irq;
	assign o_diag_irq          = s_ff.diag_irq;
	assign o_diag_buf_we       = s_ff.buf_we;
	assign o_diag_buf_src      = s_ff.buf_src;
	assign o_diag_buf_out      = s_ff.buf_out;
	assign o_sys_fault_led     = s_ff.system_fault_indicator;
	assign o_pulse_led         = s_ff.pulse_led;
	assign o_out_gnd_fault_led = s_ff.gnd_led;
	assign o_elec_sup_led      = s_ff.sup_led[0];
	assign o_in_sup_led        = s_ff.sup_led[2];
	assign o_out_sup_led       = s_ff.sup_led[1];
endmodule

// ==== test/pdiu_checker.sv ====
// Assertion checker for the interrupt unit ports
`timescale 1ns/1ps
`include "pdiu_params.svh"
module pdiu_checker (
	input wire logic        i_mclk,
	input wire logic        i_rstn,
	input wire logic [7:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic        i_do_short,
	input wire logic [1:0]  i_pulse_out,
	input wire logic [31:0] o_rdata,
	input wire logic        o_proc_irq,
	input wire logic        o_diag_irq,
	input wire logic        o_diag_buf_we,
	input wire logic        o_diag_buf_out,
	input wire logic        o_sys_fault_led,
	input wire logic [1:0]  o_pulse_led,
	input wire logic        o_out_gnd_fault_led
);
	wire ack_p = i_wr && i_addr == `PDIU_OFS_ACK && i_wdata[`PDIU_ACK_PROC];
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rstn);
	AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("read data outside answer cycle");
	AST_LED_COPY: assert property ($changed(i_pulse_out) |=> o_pulse_led == $past(i_pulse_out))
		else $error("pulse led lost output level");
	AST_GND_ON: assert property (i_do_short [*4] |-> o_out_gnd_fault_led)
		else $error("ground fault led dark on short");
	AST_GND_OFF: assert property (!i_do_short [*4] |-> !o_out_gnd_fault_led)
		else $error("ground fault led lit without short");
	AST_BUF_ONE: assert property (o_diag_buf_we |=> !o_diag_buf_we)
		else $error("buffer entry pulse too long");
	AST_DIAG_ENTRY: assert property ($rose(o_diag_irq) |-> o_diag_buf_we)
		else $error("diagnostic call without buffer entry");
	AST_PREEMPT: assert property (o_diag_irq |-> !o_proc_irq)
		else $error("process handler runs beside diagnostic");
	AST_FAULT_IN: assert property (o_diag_buf_we && !o_diag_buf_out |=> o_sys_fault_led)
		else $error("fault led dark after incoming");
	AST_PROC_HOLD: assert property ($fell(o_proc_irq) |-> o_diag_irq || $past(ack_p) || $past(ack_p, 2))
		else $error("process call dropped before return");
	COV_OUT: cover property ($rose(o_diag_irq) && o_diag_buf_out);
	COV_IN: cover property ($rose(o_diag_irq) && !o_diag_buf_out);
	COV_PROC: cover property ($rose(o_proc_irq));
endmodule
bind pdiu_top pdiu_checker pdiu_checker_i (.i_mclk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .i_do_short,
	.i_pulse_out, .o_rdata, .o_proc_irq, .o_diag_irq, .o_diag_buf_we, .o_diag_buf_out, .o_sys_fault_led,
	.o_pulse_led, .o_out_gnd_fault_led);

// ==== test/pdiu_fw_model.sv ====
// Handler firmware model driving the register port
`timescale 1ns/1ps
`include "pdiu_params.svh"
module pdiu_fw_model (
	input  wire logic        i_mclk,
	input  wire logic [31:0] i_rdata,
	output logic [7:0]       o_addr,
	output logic [31:0]      o_wdata,
	output logic             o_wr,
	output logic             o_rd
);
	initial begin
		o_addr = 8'hFF;
		o_wdata = 32'h0;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_mclk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_mclk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_mclk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1 d = i_rdata;
	endtask
	// Handler return
	task ack(input logic [1:0] m);
		wr(`PDIU_OFS_ACK, {30'h0, m});
	endtask
	// Mode, selection and diagnostic enable
	task cfg(input logic [7:0] c);
		wr(`PDIU_OFS_CTRL, {24'h0, c});
	endtask
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the interrupt unit
`timescale 1ns/1ps
`include "pdiu_params.svh"
module tb_top;
	logic        i_mclk, i_rstn, i_wr, i_rd, i_out_sup_fail, i_in_sup_fail, i_elec_sup_fail, i_do_short;
	logic        i_cnt3_gate_open, i_cnt3_gate_close, i_cnt3_latch, o_proc_irq, o_diag_irq, o_diag_buf_we;
	logic        o_diag_buf_out, o_sys_fault_led, o_out_gnd_fault_led, o_elec_sup_led, o_in_sup_led, o_out_sup_led;
	logic [7:0]  i_addr;
	logic [15:0] i_di_pin;
	logic [3:0]  i_cnt_ovf, i_cnt_cmp, i_freq_end, o_diag_buf_src;
	logic [1:0]  i_pulse_out, o_pulse_led;
	logic [31:0] i_wdata, o_rdata, rv;
	int          n_mismatch, checks;
	pdiu_top pdiu_top_i (.i_mclk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .i_di_pin, .i_out_sup_fail,
		.i_in_sup_fail, .i_elec_sup_fail, .i_do_short, .i_cnt_ovf, .i_cnt_cmp, .i_cnt3_gate_open,
		.i_cnt3_gate_close, .i_cnt3_latch, .i_freq_end, .i_pulse_out, .o_rdata, .o_proc_irq, .o_diag_irq,
		.o_diag_buf_we, .o_diag_buf_src, .o_diag_buf_out, .o_sys_fault_led, .o_pulse_led,
		.o_out_gnd_fault_led, .o_elec_sup_led, .o_in_sup_led, .o_out_sup_led);
	pdiu_fw_model pdiu_fw_model_i (.i_mclk, .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
		.o_wr(i_wr), .o_rd(i_rd));
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	// Bounded wait for a handler request level
	task waitirq(input logic d, input logic v);
		for (int k = 0; k < 40 && (d ? o_diag_irq : o_proc_irq) !== v; k++) tick(1);
		chk(d ? o_diag_irq : o_proc_irq, v);
	endtask
	task ackw(input logic d);
		pdiu_fw_model_i.ack(d ? 2'b10 : 2'b01);
		waitirq(d, 1'b0);
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		pdiu_fw_model_i.rd(a, rv);
		chk(rv, e);
	endtask
	// Pin level plus one-cycle event pulses
	task drive(input logic [15:0] p, input logic [3:0] ovf, cmp, fe, input logic [2:0] c3);
		@(posedge i_mclk);
		i_di_pin <= p;
		i_cnt_ovf <= ovf;
		i_cnt_cmp <= cmp;
		i_freq_end <= fe;
		{i_cnt3_gate_open, i_cnt3_gate_close, i_cnt3_latch} <= c3;
		@(posedge i_mclk);
		{i_cnt_ovf, i_cnt_cmp, i_freq_end} <= 12'h000;
		{i_cnt3_gate_open, i_cnt3_gate_close, i_cnt3_latch} <= 3'h0;
	endtask
	task lvl(input logic [3:0] v);
		@(posedge i_mclk);
		{i_elec_sup_fail, i_in_sup_fail, i_out_sup_fail, i_do_short} <= v;
	endtask
	initial begin
		#100us;
		n_mismatch++;
		wrap_up;
	end
	initial begin
		i_rstn = 1'b0;
		i_di_pin = 16'h0;
		{i_out_sup_fail, i_in_sup_fail, i_elec_sup_fail, i_do_short} = 4'h0;
		{i_cnt_ovf, i_cnt_cmp, i_freq_end} = 12'h000;
		{i_cnt3_gate_open, i_cnt3_gate_close, i_cnt3_latch} = 3'h0;
		i_pulse_out = 2'h0;
		n_mismatch = 0;
		checks = 0;
		tick(2);
		chk({o_proc_irq, o_diag_irq, o_sys_fault_led}, 3'h0);
		@(posedge i_mclk);
		i_rstn <= 1'b1;
		tick(5);
		chk({o_elec_sup_led, o_in_sup_led, o_out_sup_led}, 3'b111);
		pdiu_fw_model_i.wr(`PDIU_OFS_BASE, 32'h0000_1234);
		pdiu_fw_model_i.wr(`PDIU_OFS_EDGE, 32'h0000_FFFF);
		pdiu_fw_model_i.cfg(8'h00);
		rdchk(`PDIU_OFS_BASE, 32'h0000_1234);
		rdchk(`PDIU_OFS_EDGE, 32'h0000_FFFF);
		drive(16'h0201, 4'h0, 4'h0, 4'h0, 3'h0);
		tick(10);
		chk(o_proc_irq, 1'b0);
		pdiu_fw_model_i.cfg(8'h04);
		rdchk(`PDIU_OFS_CTRL, 32'h0000_0004);
		drive(16'h0000, 4'h0, 4'h0, 4'h0, 3'h0);
		waitirq(1'b0, 1'b1);
		rdchk(`PDIU_OFS_PWORD, 32'h0000_0201);
		pdiu_fw_model_i.ack(2'b10);
		tick(3);
		chk(o_proc_irq, 1'b1);
		pdiu_fw_model_i.rd(`PDIU_OFS_STAT, rv);
		chk(rv[31:16], 16'h1234);
		ackw(1'b0);
		pdiu_fw_model_i.cfg(8'h15);
		pdiu_fw_model_i.wr(`PDIU_OFS_TRIG, 32'h0000_07FF);
		rdchk(`PDIU_OFS_TRIG, 32'h0000_07FF);
		drive(16'h0000, 4'hA, 4'h5, 4'h0, 3'h7);
		waitirq(1'b0, 1'b1);
		rdchk(`PDIU_OFS_PWORD, 32'h1708_0408);
		ackw(1'b0);
		pdiu_fw_model_i.cfg(8'h05);
		drive(16'h0000, 4'h0, 4'h0, 4'h0, 3'h6);
		tick(10);
		chk(o_proc_irq, 1'b0);
		pdiu_fw_model_i.cfg(8'h06);
		pdiu_fw_model_i.wr(`PDIU_OFS_TRIG, 32'h0000_7800);
		drive(16'h0000, 4'h0, 4'h0, 4'hF, 3'h0);
		waitirq(1'b0, 1'b1);
		rdchk(`PDIU_OFS_PWORD, 32'h0101_0101);
		ackw(1'b0);
		pdiu_fw_model_i.cfg(8'h07);
		drive(16'h0000, 4'hF, 4'hF, 4'hF, 3'h7);
		tick(10);
		chk(o_proc_irq, 1'b0);
		pdiu_fw_model_i.cfg(8'h0D);
		pdiu_fw_model_i.wr(`PDIU_OFS_TRIG, 32'h0000_00F0);
		drive(16'h0000, 4'h0, 4'h1, 4'h0, 3'h0);
		waitirq(1'b0, 1'b1);
		drive(16'h0000, 4'h0, 4'h1, 4'h0, 3'h0);
		waitirq(1'b1, 1'b1);
		chk({o_proc_irq, o_sys_fault_led}, 2'b01);
		rdchk(`PDIU_OFS_DWORD, 32'h0000_0000);
		drive(16'h0000, 4'h0, 4'h3, 4'h0, 3'h0);
		ackw(1'b1);
		waitirq(1'b0, 1'b1);
		rdchk(`PDIU_OFS_PWORD, 32'h0000_0008);
		pdiu_fw_model_i.ack(2'b01);
		waitirq(1'b1, 1'b1);
		pdiu_fw_model_i.rd(`PDIU_OFS_STAT, rv);
		chk(rv[10:0], 11'h006);
		rdchk(`PDIU_OFS_DWORD, 32'h0000_0001);
		ackw(1'b1);
		waitirq(1'b0, 1'b1);
		rdchk(`PDIU_OFS_PWORD, 32'h0000_0800);
		chk(o_sys_fault_led, 1'b0);
		ackw(1'b0);
		lvl(4'b0010);
		waitirq(1'b1, 1'b1);
		rdchk(`PDIU_OFS_DWORD, 32'h0000_0008);
		chk(o_out_sup_led, 1'b0);
		ackw(1'b1);
		lvl(4'b0000);
		waitirq(1'b1, 1'b1);
		rdchk(`PDIU_OFS_DWORD, 32'h0000_0009);
		ackw(1'b1);
		lvl(4'b0100);
		waitirq(1'b1, 1'b1);
		chk({o_diag_buf_src, o_diag_buf_out, o_in_sup_led}, 6'b0101_00);
		rdchk(`PDIU_OFS_DWORD, 32'h0000_000A);
		ackw(1'b1);
		lvl(4'b1100);
		tick(6);
		chk({o_diag_irq, o_elec_sup_led, o_in_sup_led, o_out_sup_led}, 4'b0001);
		lvl(4'b0000);
		waitirq(1'b1, 1'b1);
		rdchk(`PDIU_OFS_DWORD, 32'h0000_000B);
		ackw(1'b1);
		lvl(4'b0001);
		waitirq(1'b1, 1'b1);
		rdchk(`PDIU_OFS_DWORD, 32'h0000_000C);
		chk(o_out_gnd_fault_led, 1'b1);
		ackw(1'b1);
		pdiu_fw_model_i.cfg(8'h05);
		lvl(4'b0000);
		tick(10);
		chk({o_diag_irq, o_sys_fault_led, o_out_gnd_fault_led}, 3'h0);
		chk({o_elec_sup_led, o_in_sup_led, o_out_sup_led}, 3'b111);
		@(posedge i_mclk);
		i_pulse_out <= 2'b10;
		tick(2);
		chk(o_pulse_led, 2'b10);
		@(posedge i_mclk);
		i_pulse_out <= 2'b01;
		tick(2);
		chk(o_pulse_led, 2'b01);
		rdchk(8'hFC, 32'h0);
		wrap_up;
	end
endmodule
